// ===== hdl/ckm_pkg.sv
// How it works
// - Hold ten-bit PLL settle count, wait ticks.
// - Tick is main clock/256, only oscillator on.
// - Both settle counts reset to 0xb0.
// - Both settle counters run together off one shared tick.
// - PLL count write needs key 0x59c1; key reads zero.
// - PLL count write ignored while PLL on.
// - Multiplier 2..20 taken; other values ignored.
// - PLL output is input clock times multiplier.
// - Bit 15 selects PLL output or half.
// - Multiplier write needs key 0x762d; reads zero.
// - Multiplier register write refused while PLL on.
// - Ten-bit oscillator count; software programs it.
// - Oscillator count write needs key 0xdb5a.
// - Divided clock is main/(2*(value+1)), reset 0x1f.
// - Divider write needs key 0xacdc; key reads zero.
// - PLL on status gates PLL register writes.
package ckm_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte addresses.
	localparam logic [31:0] PST_ADDR  = 32'hffec000c;
	localparam logic [31:0] PD_ADDR   = 32'hffec0010;
	localparam logic [31:0] OS_ADDR   = 32'hffec0014;
	localparam logic [31:0] MAIN_DIVIDER_VALUE_ADDR = 32'hffec0018;
	localparam logic [31:0] STAT_ADDR = 32'hffec001c;

	////////////////////////////////////////////////////////////////////////////////
	// Write keys, carried in the upper half of the written word.
	localparam logic [15:0] PST_KEY  = 16'h59c1;
	localparam logic [15:0] PD_KEY   = 16'h762d;
	localparam logic [15:0] OS_KEY   = 16'hdb5a;
	localparam logic [15:0] MAIN_DIVIDER_VALUE_KEY = 16'hacdc;
	localparam int          KEY_LSB  = 16;

	////////////////////////////////////////////////////////////////////////////////
	// Field layout.
	localparam int SETTLE_W  = 10;
	localparam int MULT_W    = 5;
	localparam int DIV_W     = 7;
	localparam int HALF_BIT  = 15;
	localparam int PRE_W     = 8;
	localparam int PRESCALE  = 256;

	localparam logic [MULT_W-1:0] MULT_MIN = 5'h02;
	localparam logic [MULT_W-1:0] MULT_MAX = 5'h14;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [SETTLE_W-1:0] SETTLE_RESET = 10'h0b0;
	localparam logic [MULT_W-1:0]   MULT_RESET   = 5'h02;
	localparam logic [DIV_W-1:0]    DIV_RESET    = 7'h1f;

	////////////////////////////////////////////////////////////////////////////////
	// Settle counter states.
	typedef enum logic [1:0]
	{
		CKM_SETTLE_IDLE,
		CKM_SETTLE_COUNT,
		CKM_SETTLE_DONE
	} ckm_settle_state_t;

endpackage

// ===== hdl/ckm_settle_if.sv
`timescale 1ns/1ps
`default_nettype none
// Links the top to one settle counter.
interface ckm_settle_if;
	logic                          enable;
	logic                          tick;
	logic [ckm_pkg::SETTLE_W-1:0]  load_value;
	logic                          stable;
	logic [ckm_pkg::SETTLE_W-1:0]  remaining;

	modport ctrl
	(
		output enable,
		output tick,
		output load_value,
		input  stable,
		input  remaining
	);

	modport unit
	(
		input  enable,
		input  tick,
		input  load_value,
		output stable,
		output remaining
	);
endinterface
`default_nettype wire

// ===== hdl/ckm_settle.sv
`timescale 1ns/1ps
`default_nettype none
module ckm_settle
(
	input  wire logic    clk_i,
	input  wire logic    rst_n_i,
	ckm_settle_if.unit   port_u
);

	ckm_pkg::ckm_settle_state_t    state_q;
	ckm_pkg::ckm_settle_state_t    state_d;
	logic [ckm_pkg::SETTLE_W-1:0]  cnt_q;
	logic [ckm_pkg::SETTLE_W-1:0]  cnt_d;

	////////////////////////////////////////////////////////////////////////////////
	// Load on enable, count down on ticks, report stable at zero.
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			ckm_pkg::CKM_SETTLE_IDLE:
			begin
				if (port_u.enable)
				begin
					cnt_d   = port_u.load_value;
					state_d = (port_u.load_value == '0) ? ckm_pkg::CKM_SETTLE_DONE
						: ckm_pkg::CKM_SETTLE_COUNT;
				end
			end
			ckm_pkg::CKM_SETTLE_COUNT:
			begin
				if (!port_u.enable)
					state_d = ckm_pkg::CKM_SETTLE_IDLE;
				else if (port_u.tick)
				begin
					cnt_d = cnt_q - 1'b1;
					if (cnt_q == 10'h001)
						state_d = ckm_pkg::CKM_SETTLE_DONE;
				end
			end
			default:
			begin
				if (!port_u.enable)
					state_d = ckm_pkg::CKM_SETTLE_IDLE;
			end
		endcase
	end

	// State registers.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= ckm_pkg::CKM_SETTLE_IDLE;
			cnt_q   <= '0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// Stable only once the count has run out while the source stays on.
	assign port_u.stable    = (state_q == ckm_pkg::CKM_SETTLE_DONE) && port_u.enable;
	assign port_u.remaining = cnt_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	property p_last_tick;
		@(posedge clk_i) disable iff (!rst_n_i)
		(state_q == ckm_pkg::CKM_SETTLE_COUNT && port_u.enable && port_u.tick
			&& cnt_q == 10'h001) |=> (state_q == ckm_pkg::CKM_SETTLE_DONE) && (cnt_q == '0);
	endproperty
	a_last_tick: assert property (p_last_tick) else $error("settle did not finish");

	property p_no_tick_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		(state_q == ckm_pkg::CKM_SETTLE_COUNT && port_u.enable && !port_u.tick)
			|=> $stable(cnt_q) && !port_u.stable;
	endproperty
	a_no_tick_hold: assert property (p_no_tick_hold) else $error("count moved without tick");

endmodule
`default_nettype wire

// ===== hdl/ckm_top.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ckm_top
(
	input  wire logic        REF_CLK_I,
	input  wire logic        RST_N_I,
	input  wire logic [31:0] ADDR_I,
	input  wire logic [31:0] WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [31:0] RDATA_O,
	input  wire logic        PLL_ON_STATUS_I,
	input  wire logic        MAIN_OSC_ON_STATUS_I,
	output logic      [4:0]  PLL_MULTIPLIER_O,
	output logic             PLL_HALF_SELECT_O,
	output logic             PLL_STABLE_O,
	output logic             OSC_STABLE_O,
	output logic             DIVIDED_CLOCK_O
);

	localparam logic [ckm_pkg::PRE_W-1:0] PRE_LAST = ckm_pkg::PRE_W'(ckm_pkg::PRESCALE - 1);

	if (ckm_pkg::PRESCALE != (1 << ckm_pkg::PRE_W))
	begin : g_bad_prescale
		$error("prescaler width does not match its ratio");
	end

	// Key check shared by all keyed registers.
	function automatic logic key_ok(input logic [31:0] data, input logic [15:0] key);
		return data[31:ckm_pkg::KEY_LSB] == key;
	endfunction

	logic [ckm_pkg::SETTLE_W-1:0] pll_settle_count_q;
	logic [ckm_pkg::SETTLE_W-1:0] pll_settle_count_d;
	logic [ckm_pkg::SETTLE_W-1:0] osc_settle_count_q;
	logic [ckm_pkg::SETTLE_W-1:0] osc_settle_count_d;
	logic [ckm_pkg::MULT_W-1:0]   pll_multiplier_q;
	logic [ckm_pkg::MULT_W-1:0]   pll_multiplier_d;
	logic                         pll_half_select_q;
	logic                         pll_half_select_d;
	logic [ckm_pkg::DIV_W-1:0]    main_divider_value_q;
	logic [ckm_pkg::DIV_W-1:0]    main_divider_value_d;
	logic [31:0]                  rdata_q;
	logic [31:0]                  rdata_d;
	logic [ckm_pkg::PRE_W-1:0]    pre_q;
	logic [ckm_pkg::PRE_W-1:0]    pre_d;
	logic                         tick_q;
	logic                         tick_d;
	logic [ckm_pkg::DIV_W-1:0]    div_cnt_q;
	logic [ckm_pkg::DIV_W-1:0]    div_cnt_d;
	logic                         divided_clock_q;
	logic                         divided_clock_d;
	logic [4:0]                   new_mult;

	ckm_settle_if pll_link ();
	ckm_settle_if osc_link ();

	////////////////////////////////////////////////////////////////////////////////
	// Register writes and reads.
	always_comb
	begin
		pll_settle_count_d   = pll_settle_count_q;
		osc_settle_count_d   = osc_settle_count_q;
		pll_multiplier_d     = pll_multiplier_q;
		pll_half_select_d    = pll_half_select_q;
		main_divider_value_d = main_divider_value_q;
		rdata_d              = '0;
		new_mult             = WDATA_I[ckm_pkg::MULT_W-1:0];
		if (WR_I)
		begin
			if (ADDR_I == ckm_pkg::PST_ADDR)
			begin
				// The PLL must be off and the key must match.
				if (key_ok(WDATA_I, ckm_pkg::PST_KEY) && !PLL_ON_STATUS_I)
					pll_settle_count_d = WDATA_I[ckm_pkg::SETTLE_W-1:0];
			end
			else if (ADDR_I == ckm_pkg::PD_ADDR)
			begin
				if (key_ok(WDATA_I, ckm_pkg::PD_KEY) && !PLL_ON_STATUS_I)
				begin
					pll_half_select_d = WDATA_I[ckm_pkg::HALF_BIT];
					// Out of range factors keep the previous one.
					if (new_mult >= ckm_pkg::MULT_MIN && new_mult <= ckm_pkg::MULT_MAX)
						pll_multiplier_d = new_mult;
				end
			end
			else if (ADDR_I == ckm_pkg::OS_ADDR)
			begin
				if (key_ok(WDATA_I, ckm_pkg::OS_KEY))
					osc_settle_count_d = WDATA_I[ckm_pkg::SETTLE_W-1:0];
			end
			else if (ADDR_I == ckm_pkg::MAIN_DIVIDER_VALUE_ADDR)
			begin
				if (key_ok(WDATA_I, ckm_pkg::MAIN_DIVIDER_VALUE_KEY))
					main_divider_value_d = WDATA_I[ckm_pkg::DIV_W-1:0];
			end
		end
		if (RD_I)
		begin
			// Key fields always read back as zero.
			if (ADDR_I == ckm_pkg::PST_ADDR)
				rdata_d = {22'h000000, pll_settle_count_q};
			else if (ADDR_I == ckm_pkg::PD_ADDR)
				rdata_d = {16'h0000, pll_half_select_q, 10'h000, pll_multiplier_q};
			else if (ADDR_I == ckm_pkg::OS_ADDR)
				rdata_d = {22'h000000, osc_settle_count_q};
			else if (ADDR_I == ckm_pkg::MAIN_DIVIDER_VALUE_ADDR)
				rdata_d = {25'h0000000, main_divider_value_q};
			else if (ADDR_I == ckm_pkg::STAT_ADDR)
				rdata_d = {8'h00, pll_link.remaining, osc_link.remaining,
					PLL_ON_STATUS_I, MAIN_OSC_ON_STATUS_I, pll_link.stable, osc_link.stable};
		end
	end

	// Register file flops.
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			pll_settle_count_q   <= ckm_pkg::SETTLE_RESET;
			osc_settle_count_q   <= ckm_pkg::SETTLE_RESET;
			pll_multiplier_q     <= ckm_pkg::MULT_RESET;
			pll_half_select_q    <= 1'b0;
			main_divider_value_q <= ckm_pkg::DIV_RESET;
			rdata_q              <= '0;
		end
		else
		begin
			pll_settle_count_q   <= pll_settle_count_d;
			osc_settle_count_q   <= osc_settle_count_d;
			pll_multiplier_q     <= pll_multiplier_d;
			pll_half_select_q    <= pll_half_select_d;
			main_divider_value_q <= main_divider_value_d;
			rdata_q              <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stabilization time base: one tick per 256 clocks, only with the oscillator on.
	always_comb
	begin
		pre_d  = MAIN_OSC_ON_STATUS_I ? pre_q + 1'b1 : '0;
		tick_d = MAIN_OSC_ON_STATUS_I && (pre_q == PRE_LAST);
	end

	// Prescaler flops.
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			pre_q  <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			pre_q  <= pre_d;
			tick_q <= tick_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Both counters share one tick, so they run down side by side.
	assign pll_link.enable     = PLL_ON_STATUS_I;
	assign pll_link.tick       = tick_q;
	assign pll_link.load_value = pll_settle_count_q;
	assign osc_link.enable     = MAIN_OSC_ON_STATUS_I;
	assign osc_link.tick       = tick_q;
	assign osc_link.load_value = osc_settle_count_q;

	ckm_settle u_pll_settle
	(
		.clk_i   (REF_CLK_I),
		.rst_n_i (RST_N_I),
		.port_u  (pll_link)
	);

	ckm_settle u_osc_settle
	(
		.clk_i   (REF_CLK_I),
		.rst_n_i (RST_N_I),
		.port_u  (osc_link)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Divided clock: toggle each value+1 clocks, period 2*(value+1).
	always_comb
	begin
		div_cnt_d       = div_cnt_q + 1'b1;
		divided_clock_d = divided_clock_q;
		if (div_cnt_q >= main_divider_value_q)
		begin
			div_cnt_d       = '0;
			divided_clock_d = !divided_clock_q;
		end
	end

	// Divider flops.
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			div_cnt_q       <= '0;
			divided_clock_q <= 1'b0;
		end
		else
		begin
			div_cnt_q       <= div_cnt_d;
			divided_clock_q <= divided_clock_d;
		end
	end

	// Outputs; the multiplier sets the PLL output to input clock times factor.
	assign RDATA_O           = rdata_q;
	assign PLL_MULTIPLIER_O  = pll_multiplier_q;
	assign PLL_HALF_SELECT_O = pll_half_select_q;
	assign PLL_STABLE_O      = pll_link.stable;
	assign OSC_STABLE_O      = osc_link.stable;
	assign DIVIDED_CLOCK_O   = divided_clock_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	property p_pst_refused;
		@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(WR_I && ADDR_I == ckm_pkg::PST_ADDR
			&& (WDATA_I[31:16] != ckm_pkg::PST_KEY || PLL_ON_STATUS_I)) |=> $stable(pll_settle_count_q);
	endproperty
	a_pst_refused: assert property (p_pst_refused) else $error("bad PLL count write taken");

	property p_pst_taken;
		@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(WR_I && ADDR_I == ckm_pkg::PST_ADDR && WDATA_I[31:16] == ckm_pkg::PST_KEY
			&& !PLL_ON_STATUS_I) |=> pll_settle_count_q == $past(WDATA_I[9:0]);
	endproperty
	a_pst_taken: assert property (p_pst_taken) else $error("good PLL count write lost");

	property p_mult_range;
		@(posedge REF_CLK_I) disable iff (!RST_N_I)
		PLL_MULTIPLIER_O >= 5'h02 && PLL_MULTIPLIER_O <= 5'h14;
	endproperty
	a_mult_range: assert property (p_mult_range) else $error("multiplier out of range");

	property p_pd_locked;
		@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(WR_I && ADDR_I == ckm_pkg::PD_ADDR && PLL_ON_STATUS_I)
			|=> $stable(pll_multiplier_q) && $stable(pll_half_select_q);
	endproperty
	a_pd_locked: assert property (p_pd_locked) else $error("PLL divider written while on");

	property p_pd_key;
		@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(WR_I && ADDR_I == ckm_pkg::PD_ADDR && WDATA_I[31:16] == ckm_pkg::PD_KEY
			&& !PLL_ON_STATUS_I) |=> PLL_HALF_SELECT_O == $past(WDATA_I[15]);
	endproperty
	a_pd_key: assert property (p_pd_key) else $error("half select not taken");

	property p_os_key;
		@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(WR_I && ADDR_I == ckm_pkg::OS_ADDR && WDATA_I[31:16] != ckm_pkg::OS_KEY)
			|=> $stable(osc_settle_count_q);
	endproperty
	a_os_key: assert property (p_os_key) else $error("bad oscillator key taken");

	property p_div_key;
		@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(WR_I && ADDR_I == ckm_pkg::MAIN_DIVIDER_VALUE_ADDR && WDATA_I[31:16] != ckm_pkg::MAIN_DIVIDER_VALUE_KEY)
			|=> $stable(main_divider_value_q);
	endproperty
	a_div_key: assert property (p_div_key) else $error("bad divider key taken");

	property p_key_reads_zero;
		@(posedge REF_CLK_I) disable iff (!RST_N_I)
		RD_I |=> RDATA_O[31:16] == 16'h0000;
	endproperty
	a_key_reads_zero: assert property (p_key_reads_zero) else $error("key field read nonzero");

	property p_tick_needs_osc;
		@(posedge REF_CLK_I) disable iff (!RST_N_I)
		!MAIN_OSC_ON_STATUS_I |=> !tick_q ##1 !tick_q [*1];
	endproperty
	a_tick_needs_osc: assert property (p_tick_needs_osc) else $error("tick without oscillator");

	property p_div_toggle;
		@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(div_cnt_q < main_divider_value_q) |=> $stable(DIVIDED_CLOCK_O);
	endproperty
	a_div_toggle: assert property (p_div_toggle) else $error("divided clock toggled early");

	property p_div_flip;
		@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(div_cnt_q >= main_divider_value_q) |=> DIVIDED_CLOCK_O != $past(DIVIDED_CLOCK_O);
	endproperty
	a_div_flip: assert property (p_div_flip) else $error("divided clock missed toggle");

endmodule
`default_nettype wire

// ===== tb/clock_manager_pll_dividers_tb.sv
`timescale 1ns/1ps
`default_nettype none
module clock_manager_pll_dividers_tb;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [31:0] addr = 32'h0;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic        pll_on = 1'b0;
	logic        osc_on = 1'b0;
	logic [4:0]  mult;
	logic        half;
	logic        pll_stable;
	logic        osc_stable;
	logic        div_clk;
	integer      seed = 45520;
	int          failures = 0;
	int          samples_checked = 0;
	logic [9:0]  m_pst = 10'h0b0;
	logic [9:0]  m_os = 10'h0b0;
	logic [4:0]  m_mult = 5'h02;
	logic        m_half = 1'b0;
	logic [6:0]  m_div = 7'h1f;
	logic [31:0] regs [4] = '{ckm_pkg::PST_ADDR, ckm_pkg::PD_ADDR, ckm_pkg::OS_ADDR,
		ckm_pkg::MAIN_DIVIDER_VALUE_ADDR};

	////////////////////////////////////////////////////////////////////////////////
	// Free-running 125 MHz clock.
	always #4 ref_clk = ~ref_clk;

	ckm_top i_dut
	(
		.REF_CLK_I            (ref_clk),
		.RST_N_I              (rst_n),
		.ADDR_I               (addr),
		.WDATA_I              (wdata),
		.WR_I                 (wr),
		.RD_I                 (rd),
		.RDATA_O              (rdata),
		.PLL_ON_STATUS_I      (pll_on),
		.MAIN_OSC_ON_STATUS_I (osc_on),
		.PLL_MULTIPLIER_O     (mult),
		.PLL_HALF_SELECT_O    (half),
		.PLL_STABLE_O         (pll_stable),
		.OSC_STABLE_O         (osc_stable),
		.DIVIDED_CLOCK_O      (div_clk)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then stops the run.
	task automatic finish_test();
		$display("Counts: %0d compared, %0d mismatched", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Returns the write key that unlocks the register at the given address.
	function automatic logic [15:0] key_of(input logic [31:0] a);
		case (a)
			ckm_pkg::PST_ADDR: return ckm_pkg::PST_KEY;
			ckm_pkg::PD_ADDR:  return ckm_pkg::PD_KEY;
			ckm_pkg::OS_ADDR:  return ckm_pkg::OS_KEY;
			default:           return ckm_pkg::MAIN_DIVIDER_VALUE_KEY;
		endcase
	endfunction

	// Returns the word a read should give; key fields always read as zero.
	function automatic logic [31:0] exp_rd(input logic [31:0] a);
		case (a)
			ckm_pkg::PST_ADDR:  return {22'h0, m_pst};
			ckm_pkg::PD_ADDR:   return {16'h0, m_half, 10'h0, m_mult};
			ckm_pkg::OS_ADDR:   return {22'h0, m_os};
			ckm_pkg::MAIN_DIVIDER_VALUE_ADDR: return {25'h0, m_div};
			// Status is only read once both counts have run out.
			ckm_pkg::STAT_ADDR: return {28'h0, pll_on, osc_on, pll_on, osc_on};
			default:            return 32'h0;
		endcase
	endfunction

	// One write cycle, then the expected register state is updated.
	task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
		logic ok;
		@(posedge ref_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr <= 1'b0;
		ok = (d[31:16] == key_of(a));
		if (ok && !pll_on && a == ckm_pkg::PST_ADDR)
			m_pst = d[9:0];
		if (ok && !pll_on && a == ckm_pkg::PD_ADDR)
		begin
			m_half = d[15];
			if (d[4:0] >= 5'h02 && d[4:0] <= 5'h14)
				m_mult = d[4:0];
		end
		if (ok && a == ckm_pkg::OS_ADDR)
			m_os = d[9:0];
		if (ok && a == ckm_pkg::MAIN_DIVIDER_VALUE_ADDR)
			m_div = d[6:0];
	endtask

	// One read cycle; the data is taken in the cycle after the strobe.
	task automatic rd_chk(input logic [31:0] a);
		@(posedge ref_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd <= 1'b0;
		@(negedge ref_clk);
		chk(rdata, exp_rd(a));
	endtask

	// Measures period and high time of the divided clock over one full cycle.
	task automatic div_measure(output int p, output int hi);
		int   n;
		int   rises;
		int   t0;
		logic last;
		rises = 0;
		hi = 0;
		p = 0;
		t0 = 0;
		last = div_clk;
		for (n = 0; n < 2000 && rises < 3; n++)
		begin
			@(negedge ref_clk);
			if (div_clk && !last)
			begin
				rises++;
				if (rises == 2)
					t0 = n;
				if (rises == 3)
					p = n - t0;
			end
			if (rises == 2 && div_clk)
				hi++;
			last = div_clk;
		end
		if (rises < 3)
		begin
			failures++;
			finish_test();
		end
	endtask

	// True when a settle time lies within a few cycles of n prescaler ticks.
	function automatic logic in_win(input int t, input int n);
		return (t >= n * 256 - 2) && (t <= n * 256 + 4);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		int          p;
		int          hi;
		int          t_os;
		int          t_pll;
		logic [31:0] a;
		logic [31:0] d;
		logic [6:0]  dv [3];
		dv = '{7'h00, 7'h03, 7'h7f};
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(negedge ref_clk);
		chk({27'h0, mult}, 32'h2);
		chk({31'h0, half}, 32'h0);
		chk(rdata, 32'h0);
		foreach (regs[i])
			rd_chk(regs[i]);
		rd_chk(32'hffec0020);
		$display("Test reset_values done");

		// Every multiplier code, with the halving bit taken from code bit 1.
		for (int v = 0; v < 32; v++)
		begin
			bus_wr(ckm_pkg::PD_ADDR, {ckm_pkg::PD_KEY, v[1], 10'h0, v[4:0]});
			rd_chk(ckm_pkg::PD_ADDR);
			chk({27'h0, mult}, {27'h0, m_mult});
			chk({31'h0, half}, {31'h0, m_half});
		end
		$display("Test multiplier_codes done");

		// Right key while the PLL runs, then wrong keys with the PLL stopped.
		@(posedge ref_clk);
		pll_on <= 1'b1;
		bus_wr(ckm_pkg::PST_ADDR, {ckm_pkg::PST_KEY, 16'h0123});
		rd_chk(ckm_pkg::PST_ADDR);
		bus_wr(ckm_pkg::PD_ADDR, {ckm_pkg::PD_KEY, 16'h8007});
		rd_chk(ckm_pkg::PD_ADDR);
		@(posedge ref_clk);
		pll_on <= 1'b0;
		foreach (regs[i])
		begin
			bus_wr(regs[i], {key_of(regs[i]) ^ 16'h0001, 16'h0005});
			rd_chk(regs[i]);
		end
		$display("Test write_keys done");

		// Random writes, keys right half the time, PLL status random.
		for (int i = 0; i < 80; i++)
		begin
			a = regs[$unsigned($random(seed)) % 4];
			d = $random(seed);
			if ($random(seed) & 1)
				d[31:16] = key_of(a);
			@(posedge ref_clk);
			pll_on <= 1'($random(seed) & 1);
			bus_wr(a, d);
			rd_chk(a);
		end
		@(posedge ref_clk);
		pll_on <= 1'b0;
		$display("Test random_writes done");

		// Divided clock at the smallest, a small (3) and the largest divider.
		foreach (dv[i])
		begin
			bus_wr(ckm_pkg::MAIN_DIVIDER_VALUE_ADDR, {ckm_pkg::MAIN_DIVIDER_VALUE_KEY, 9'h0, dv[i]});
			div_measure(p, hi);
			chk(p, 2 * (dv[i] + 1));
			chk(hi, dv[i] + 1);
		end
		$display("Test divided_clock done");

		// PLL settle count must not advance while the oscillator is off.
		bus_wr(ckm_pkg::PST_ADDR, {ckm_pkg::PST_KEY, 16'h0001});
		@(posedge ref_clk);
		pll_on <= 1'b1;
		repeat (600) @(negedge ref_clk);
		chk({31'h0, pll_stable}, 32'h0);
		@(posedge ref_clk);
		pll_on <= 1'b0;

		// Both sources enabled together: the two counts run in parallel.
		bus_wr(ckm_pkg::OS_ADDR, {ckm_pkg::OS_KEY, 16'h0002});
		bus_wr(ckm_pkg::PST_ADDR, {ckm_pkg::PST_KEY, 16'h0003});
		rd_chk(ckm_pkg::OS_ADDR);
		@(posedge ref_clk);
		osc_on <= 1'b1;
		pll_on <= 1'b1;
		t_os = -1;
		t_pll = -1;
		for (int n = 1; n < 1200 && t_pll < 0; n++)
		begin
			@(negedge ref_clk);
			if (t_os < 0 && osc_stable === 1'b1)
				t_os = n;
			if (t_pll < 0 && pll_stable === 1'b1)
				t_pll = n;
		end
		chk({31'h0, in_win(t_os, 2)}, 32'h1);
		chk({31'h0, in_win(t_pll, 3)}, 32'h1);
		rd_chk(ckm_pkg::STAT_ADDR);
		@(posedge ref_clk);
		pll_on <= 1'b0;
		@(negedge ref_clk);
		chk({30'h0, pll_stable, osc_stable}, 32'h1);
		@(posedge ref_clk);
		osc_on <= 1'b0;
		@(negedge ref_clk);
		chk({31'h0, osc_stable}, 32'h0);
		$display("Test settle_counters done");
		finish_test();
	end
endmodule
`default_nettype wire
